//--- rxmm_pkg.sv
// Shared constants for the dual-group management serial slave and its master
package rxmm_pkg;
  // Frame layout
  localparam logic [5:0]  PRE_CNT_MAX   = 6'h20;
  localparam logic [4:0]  HDR_LAST      = 5'h0c;
  localparam logic [4:0]  TA_LAST       = 5'h01;
  localparam logic [4:0]  DATA_LAST     = 5'h0f;
  localparam logic [5:0]  FRAME_LAST    = 6'h3f;
  localparam logic [5:0]  PRE_BITS      = 6'h20;
  localparam logic [5:0]  RD_REL_BIT    = 6'h2e;
  localparam logic [5:0]  RD_DATA_BIT   = 6'h30;
  localparam logic [1:0]  ST_C45        = 2'h0;
  localparam logic [1:0]  TA_WR         = 2'h2;
  // Operation codes
  localparam logic [1:0]  OP_ADDR       = 2'h0;
  localparam logic [1:0]  OP_WRITE      = 2'h1;
  localparam logic [1:0]  OP_RD_INC     = 2'h2;
  localparam logic [1:0]  OP_READ       = 2'h3;
  // Device identities
  localparam logic [4:0]  DEVAD_PHY     = 5'h04;
  localparam logic [4:0]  DEVAD_DTE     = 5'h05;
  // Register addresses
  localparam logic [15:0] REG_LOOPBACK  = 16'h8010;
  localparam logic [15:0] REG_TEST      = 16'h8011;
  localparam logic [15:0] REG_STRAP     = 16'h8012;
  localparam logic [15:0] REG_CFG1      = 16'h8084;
  localparam logic [15:0] REG_CFG2      = 16'h8085;
  // Field positions
  localparam int          CFG1_EQ_EN    = 2;
  localparam int          CFG1_EQ_BW    = 3;
  localparam int          CFG1_AMP_REF  = 6;
  localparam int          CFG1_PE_LSB   = 11;
  localparam int          CFG1_PE_MSB   = 14;
  localparam int          CFG2_BW_LSB   = 13;
  localparam int          CFG2_BW_MSB   = 14;
  localparam int          LB_XGMII      = 0;
  localparam int          LB_XAUI       = 1;
  localparam int          TEST_SEL_LSB  = 0;
  localparam int          TEST_SEL_MSB  = 2;
  localparam int          TEST_EN       = 3;
  // Test pattern codes
  localparam logic [2:0]  PAT_PRBS7     = 3'h0;
  localparam logic [2:0]  PAT_PRBS23    = 3'h1;
  localparam logic [2:0]  PAT_CJPAT     = 3'h2;
  localparam logic [2:0]  PAT_CRPAT     = 3'h3;
  localparam logic [2:0]  PAT_HIGH      = 3'h4;
  localparam logic [2:0]  PAT_LOW       = 3'h5;
  localparam logic [2:0]  PAT_MIXED     = 3'h6;
  // Reset values
  localparam logic [15:0] CFG1_RST      = 16'h0000;
  localparam logic [15:0] CFG2_RST      = 16'h0000;
  localparam logic [1:0]  LB_RST        = 2'h0;
  localparam logic [3:0]  TEST_RST      = 4'h0;
  localparam logic [15:0] ADDR_RST      = 16'h0000;
  // Management clock timing
  localparam int          CLK_NS        = 10;
  localparam int          MDC_HALF_NS   = 40;
  localparam logic [2:0]  MDC_HALF_CYC  =
    3'((MDC_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0]  MDC_LAST_CYC  = 3'(2 * MDC_HALF_CYC - 1);
endpackage

//--- rxmm_if.sv
// Management clock and shared data line between master and slave
`timescale 1ns/10ps
interface rxmm_if;
  logic mdc;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  logic mdio;

  // Line is pulled up when nobody drives it
  assign mdio = host_oe ? host_o : (dev_oe ? dev_o : 1'b1);

  modport host (output mdc, output host_o, output host_oe, input mdio);
  modport dev  (input mdc, output dev_o, output dev_oe, input mdio);
endinterface

//--- rxmm_dev.sv
// Management slave of the redundant dual-group transceiver
// What this block does
// - Clock from station, one shared data line
// - Straps set upper port address bits
// - Lowest strap picks DTE or PHY identity
// - One storage behind both identities
// - Board straps both interfaces alike
// - Even port group A, odd group B
// - Bad writes are dropped silently
// - Bad reads return zero
// - Upper region shared across both groups
// - Address, write, read, read-increment frames
// - Runs without any management access
// - Amplitude reference select bit
// - Pre-emphasis level and mode field
// - Adaptive equalizer enable bit
// - Equalizer bandwidth from three bits
// - Per-group test pattern selection
// - Two internal loopbacks per group
// - External loopback wired outside device
`timescale 1ns/10ps
module rxmm_dev (
  rxmm_if.dev              MDIO_BUS,
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic [3:0]  PORT_ADDRESS_STRAPS,
  input  wire logic        IDENTITY_SELECT_STRAP,
  output logic             AMP_REF_SEL,
  output logic [3:0]       PREEMPH_CTRL,
  output logic             EQ_ADAPT_EN,
  output logic [2:0]       EQ_BW_SEL,
  output logic [1:0]       LOOPBACK_XGMII,
  output logic [1:0]       LOOPBACK_XAUI,
  output logic [1:0]       TEST_EN,
  output logic [2:0]       TEST_PATTERN_A,
  output logic [2:0]       TEST_PATTERN_B
);
  import rxmm_pkg::*;

  typedef enum logic [1:0] {D_PRE, D_HDR, D_TA, D_DATA} rxmm_dstate_t;

  logic         mdc_s1;
  logic         mdc_s2;
  logic         mdc_s3;
  logic         dio_s1;
  logic         dio_s2;
  logic [4:0]   strap_s1;
  logic [4:0]   strap_s2;
  logic         rise;
  rxmm_dstate_t state;
  logic [5:0]   pre_cnt;
  logic [4:0]   bit_cnt;
  logic [12:0]  hdr;
  logic [12:0]  next_hdr;
  logic [15:0]  wsh;
  logic [15:0]  rsh;
  logic [15:0]  wdata;
  logic [1:0]   op_q;
  logic         grp;
  logic         mine;
  logic         dev_ok;
  logic         is_rd;
  logic         frame_end;
  logic         wr_en;
  logic [4:0]   own_devad;
  logic [15:0]  rd_val;
  logic         dev_o;
  logic         dev_oe;
  logic [15:0]  cfg1;
  logic [15:0]  cfg2;
  logic [15:0]  addr [2];
  logic [1:0]   lb_ctl [2];
  logic [3:0]   test_ctl [2];

  // Pins and the management clock are foreign to the core clock
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mdc_s1   <= 1'b0;
      mdc_s2   <= 1'b0;
      mdc_s3   <= 1'b0;
      dio_s1   <= 1'b1;
      dio_s2   <= 1'b1;
      strap_s1 <= 5'h00;
      strap_s2 <= 5'h00;
    end else begin
      mdc_s1   <= MDIO_BUS.mdc;
      mdc_s2   <= mdc_s1;
      mdc_s3   <= mdc_s2;
      dio_s1   <= MDIO_BUS.mdio;
      dio_s2   <= dio_s1;
      strap_s1 <= {PORT_ADDRESS_STRAPS, IDENTITY_SELECT_STRAP};
      strap_s2 <= strap_s1;
    end
  end

  assign rise      = mdc_s2 & ~mdc_s3;
  assign next_hdr  = {hdr[11:0], dio_s2};
  assign own_devad = strap_s2[0] ? DEVAD_DTE : DEVAD_PHY;
  assign is_rd     = (op_q == OP_READ) || (op_q == OP_RD_INC);
  assign wdata     = {wsh[14:0], dio_s2};
  assign frame_end = rise && (state == D_DATA) && (bit_cnt == DATA_LAST);

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state   <= D_PRE;
      pre_cnt <= 6'h00;
      bit_cnt <= 5'h00;
      hdr     <= 13'h0000;
      wsh     <= 16'h0000;
      op_q    <= OP_ADDR;
      grp     <= 1'b0;
      mine    <= 1'b0;
      dev_ok  <= 1'b0;
    end else if (rise) begin
      case (state)
        D_PRE: begin
          if (dio_s2) begin
            if (pre_cnt != PRE_CNT_MAX) begin
              pre_cnt <= pre_cnt + 6'h01;
            end
          end else if (pre_cnt == PRE_CNT_MAX) begin
            state   <= D_HDR;
            bit_cnt <= 5'h00;
          end else begin
            pre_cnt <= 6'h00;
          end
        end
        D_HDR: begin
          hdr     <= next_hdr;
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == HDR_LAST) begin
            bit_cnt <= 5'h00;
            pre_cnt <= 6'h00;
            if (next_hdr[12] == ST_C45[0]) begin
              state  <= D_TA;
              op_q   <= next_hdr[11:10];
              grp    <= next_hdr[5];
              mine   <= next_hdr[9:6] == strap_s2[4:1];
              dev_ok <= next_hdr[4:0] == own_devad;
            end else begin
              state  <= D_PRE;
            end
          end
        end
        D_TA: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == TA_LAST) begin
            state   <= D_DATA;
            bit_cnt <= 5'h00;
          end
        end
        D_DATA: begin
          wsh     <= wdata;
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == DATA_LAST) begin
            state   <= D_PRE;
            bit_cnt <= 5'h00;
            pre_cnt <= 6'h00;
          end
        end
        default: begin
          state <= D_PRE;
        end
      endcase
    end
  end

  always_comb begin
    rd_val = 16'h0000;
    // unknown device or register reads zero
    if (dev_ok) begin
      case (addr[grp])
        REG_CFG1:     rd_val = cfg1;
        REG_CFG2:     rd_val = cfg2;
        REG_LOOPBACK: rd_val = {14'h0000, lb_ctl[grp]};
        REG_TEST:     rd_val = {12'h000, test_ctl[grp]};
        REG_STRAP:    rd_val = {10'h000, strap_s2, grp};
        default:      rd_val = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dev_o  <= 1'b1;
      dev_oe <= 1'b0;
      rsh    <= 16'h0000;
    end else if (rise) begin
      if (mine && is_rd && state == D_TA) begin
        if (bit_cnt == TA_LAST) begin
          dev_o <= rd_val[15];
          rsh   <= {rd_val[14:0], 1'b0};
        end else begin
          dev_oe <= 1'b1;
          dev_o  <= 1'b0;
        end
      end else if (mine && is_rd && state == D_DATA) begin
        if (bit_cnt == DATA_LAST) begin
          dev_oe <= 1'b0;
          dev_o  <= 1'b1;
        end else begin
          dev_o <= rsh[15];
          rsh   <= {rsh[14:0], 1'b0};
        end
      end else begin
        dev_oe <= 1'b0;
        dev_o  <= 1'b1;
      end
    end
  end

  assign MDIO_BUS.dev_o  = dev_o;
  assign MDIO_BUS.dev_oe = dev_oe;

  // held address per group, read-increment advances it
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      addr[0] <= ADDR_RST;
      addr[1] <= ADDR_RST;
    end else if (frame_end && mine && dev_ok) begin
      if (op_q == OP_ADDR) begin
        addr[grp] <= wdata;
      end else if (op_q == OP_RD_INC) begin
        addr[grp] <= addr[grp] + 16'h0001;
      end
    end
  end

  // only implemented writable registers take a write
  assign wr_en = frame_end && mine && dev_ok && (op_q == OP_WRITE);

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg1 <= CFG1_RST;
      cfg2 <= CFG2_RST;
    end else if (wr_en) begin
      if (addr[grp] == REG_CFG1) begin
        cfg1 <= wdata;
      end
      if (addr[grp] == REG_CFG2) begin
        cfg2 <= wdata;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      lb_ctl[0]   <= LB_RST;
      lb_ctl[1]   <= LB_RST;
      test_ctl[0] <= TEST_RST;
      test_ctl[1] <= TEST_RST;
    end else if (wr_en) begin
      if (addr[grp] == REG_LOOPBACK) begin
        lb_ctl[grp] <= wdata[1:0];
      end
      if (addr[grp] == REG_TEST) begin
        test_ctl[grp] <= wdata[3:0];
      end
    end
  end

  assign AMP_REF_SEL    = cfg1[CFG1_AMP_REF];
  assign PREEMPH_CTRL   = cfg1[CFG1_PE_MSB:CFG1_PE_LSB];
  assign EQ_ADAPT_EN    = cfg1[CFG1_EQ_EN];
  assign EQ_BW_SEL      = {cfg2[CFG2_BW_MSB:CFG2_BW_LSB], cfg1[CFG1_EQ_BW]};
  assign LOOPBACK_XGMII = {lb_ctl[1][LB_XGMII], lb_ctl[0][LB_XGMII]};
  assign LOOPBACK_XAUI  = {lb_ctl[1][LB_XAUI], lb_ctl[0][LB_XAUI]};
  assign TEST_EN        = {test_ctl[1][rxmm_pkg::TEST_EN],
                           test_ctl[0][rxmm_pkg::TEST_EN]};
  assign TEST_PATTERN_A = test_ctl[0][TEST_SEL_MSB:TEST_SEL_LSB];
  assign TEST_PATTERN_B = test_ctl[1][TEST_SEL_MSB:TEST_SEL_LSB];
endmodule

//--- rxmm_host.sv
// Station management master that makes the clock and runs frames
`timescale 1ns/10ps
module rxmm_host (
  rxmm_if.host             MDIO_BUS,
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic        CMD_VALID,
  input  wire logic [1:0]  CMD_OP,
  input  wire logic [4:0]  CMD_PORT,
  input  wire logic [4:0]  CMD_DEV,
  input  wire logic [15:0] CMD_DATA,
  output logic             CMD_READY,
  output logic [15:0]      RD_DATA,
  output logic             RD_VALID
);
  import rxmm_pkg::*;

  typedef enum logic {H_IDLE, H_RUN} rxmm_hstate_t;

  rxmm_hstate_t state;
  logic         dio_s1;
  logic         dio_s2;
  logic [2:0]   phase;
  logic [5:0]   bit_cnt;
  logic [31:0]  frame;
  logic [15:0]  rsh;
  logic         rd_op;
  logic         mdc;
  logic         host_o;
  logic         host_oe;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dio_s1 <= 1'b1;
      dio_s2 <= 1'b1;
    end else begin
      dio_s1 <= MDIO_BUS.mdio;
      dio_s2 <= dio_s1;
    end
  end

  // Clock divider, bit shifting and read capture
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state     <= H_IDLE;
      phase     <= 3'h0;
      bit_cnt   <= 6'h00;
      frame     <= 32'h00000000;
      rsh       <= 16'h0000;
      rd_op     <= 1'b0;
      mdc       <= 1'b0;
      host_o    <= 1'b1;
      host_oe   <= 1'b0;
      CMD_READY <= 1'b1;
      RD_DATA   <= 16'h0000;
      RD_VALID  <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      case (state)
        H_IDLE: begin
          if (CMD_VALID) begin
            state     <= H_RUN;
            phase     <= 3'h0;
            bit_cnt   <= 6'h00;
            frame     <= {ST_C45, CMD_OP, CMD_PORT, CMD_DEV, TA_WR,
                          CMD_DATA};
            rd_op     <= CMD_OP[1];
            CMD_READY <= 1'b0;
          end
        end
        H_RUN: begin
          phase <= phase + 3'h1;
          if (phase == 3'h0) begin
            // Preamble, then frame bits; release for a read's answer
            if (bit_cnt < PRE_BITS) begin
              host_o  <= 1'b1;
              host_oe <= 1'b1;
            end else begin
              host_o  <= frame[31];
              frame   <= {frame[30:0], 1'b0};
              host_oe <= !(rd_op && bit_cnt >= RD_REL_BIT);
            end
          end
          if (phase == MDC_HALF_CYC) begin
            mdc <= 1'b1;
            if (rd_op && bit_cnt >= RD_DATA_BIT) begin
              rsh <= {rsh[14:0], dio_s2};
            end
          end
          if (phase == MDC_LAST_CYC) begin
            phase   <= 3'h0;
            mdc     <= 1'b0;
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == FRAME_LAST) begin
              state     <= H_IDLE;
              host_oe   <= 1'b0;
              host_o    <= 1'b1;
              CMD_READY <= 1'b1;
              RD_DATA   <= rsh;
              RD_VALID  <= rd_op;
            end
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  assign MDIO_BUS.mdc     = mdc;
  assign MDIO_BUS.host_o  = host_o;
  assign MDIO_BUS.host_oe = host_oe;
endmodule

//--- rxmm_assertions.sv
// Link checks between the management master and slave
`timescale 1ns/10ps
module rxmm_assertions (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic mdc,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic mdio
);
  logic [7:0] drive_cnt;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  // Cycles the slave has held the line
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      drive_cnt <= 8'h00;
    end else if (!dev_oe) begin
      drive_cnt <= 8'h00;
    end else if (drive_cnt != 8'hff) begin
      drive_cnt <= drive_cnt + 8'h01;
    end
  end

  sequence mdc_high_s;
    mdc [*3] ##1 !mdc;
  endsequence
  sequence mdc_low_s;
    !mdc [*4];
  endsequence
  sequence answer_open_s;
    !dev_o && !host_oe && !$past(host_oe, 4);
  endsequence

  one_driver_a: assert property (!(host_oe && dev_oe))
    else $error("both ends drive the data line");
  clk_high_a: assert property ($rose(mdc) |-> mdc_high_s)
    else $error("management clock high phase wrong");
  clk_low_a: assert property ($fell(mdc) |-> mdc_low_s)
    else $error("management clock low phase too short");
  host_setup_a: assert property ((host_oe && mdc) |-> $stable(host_o))
    else $error("master data moved while clock high");
  dev_setup_a: assert property (dev_oe && $rose(mdc) |-> $stable(dev_o))
    else $error("slave data moved at clock rise");
  answer_start_a: assert property ($rose(dev_oe) |-> answer_open_s)
    else $error("slave answer started wrongly");
  answer_len_a: assert property ($fell(dev_oe) |->
    (drive_cnt >= 8'd120 && drive_cnt <= 8'd140))
    else $error("slave answer length wrong");
  hold_bound_a: assert property (drive_cnt <= 8'd140)
    else $error("slave holds the line too long");
  preamble_a: assert property ($rose(host_oe) |-> host_o [*8])
    else $error("frame does not open with ones");
  turnaround_a: assert property ($fell(host_oe) |-> !dev_oe [*7])
    else $error("slave drives inside turnaround");
endmodule

//--- rxmm_tb.sv
// Bench driving master commands against the slave over the link
`timescale 1ns/10ps
module rxmm_tb;
  import rxmm_pkg::*;
  localparam logic [4:0] PA = 5'h0a;
  localparam logic [4:0] PB = 5'h0b;
  logic        core_clk;
  logic        rstn;
  logic [3:0]  straps;
  logic        id_strap;
  logic        cmd_valid;
  logic [1:0]  cmd_op;
  logic [4:0]  cmd_port;
  logic [4:0]  cmd_dev;
  logic [15:0] cmd_data;
  logic        cmd_ready;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        amp_ref;
  logic [3:0]  preemph;
  logic        eq_en;
  logic [2:0]  eq_bw;
  logic [1:0]  lb_xgmii;
  logic [1:0]  lb_xaui;
  logic [1:0]  test_en;
  logic [2:0]  pat_a;
  logic [2:0]  pat_b;
  int          fail_count;
  int          checks;
  int          cycles;

  rxmm_if bus ();
  rxmm_host u_rxmm_host (.MDIO_BUS(bus), .CORE_CLK(core_clk), .RSTN(rstn),
    .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_PORT(cmd_port),
    .CMD_DEV(cmd_dev), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready),
    .RD_DATA(rd_data), .RD_VALID(rd_valid));
  rxmm_dev u_rxmm_dev (.MDIO_BUS(bus), .CORE_CLK(core_clk), .RSTN(rstn),
    .PORT_ADDRESS_STRAPS(straps), .IDENTITY_SELECT_STRAP(id_strap),
    .AMP_REF_SEL(amp_ref), .PREEMPH_CTRL(preemph), .EQ_ADAPT_EN(eq_en),
    .EQ_BW_SEL(eq_bw), .LOOPBACK_XGMII(lb_xgmii), .LOOPBACK_XAUI(lb_xaui),
    .TEST_EN(test_en), .TEST_PATTERN_A(pat_a), .TEST_PATTERN_B(pat_b));
  rxmm_assertions u_rxmm_assertions (.CORE_CLK(core_clk), .RSTN(rstn),
    .mdc(bus.mdc), .host_o(bus.host_o), .host_oe(bus.host_oe),
    .dev_o(bus.dev_o), .dev_oe(bus.dev_oe), .mdio(bus.mdio));

  always #5 core_clk = ~core_clk;

  task automatic complete_run;
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One command is one whole frame on the link
  task automatic frame(input logic [1:0] op, input logic [4:0] port,
                       input logic [4:0] dev, input logic [15:0] data);
    int n = 0;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_port <= port;
    cmd_dev <= dev;
    cmd_data <= data;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (cmd_ready !== 1'b1 && n < 600);
    check({15'h0, cmd_ready}, 16'h0001);
    if (op[1]) begin
      check({15'h0, rd_valid}, 16'h0001);
    end else begin
      check({15'h0, rd_valid}, 16'h0000);
    end
  endtask

  task automatic wr(input logic [4:0] port, input logic [4:0] dev,
                    input logic [15:0] addr, input logic [15:0] data);
    frame(OP_ADDR, port, dev, addr);
    frame(OP_WRITE, port, dev, data);
  endtask

  task automatic rd(input logic [4:0] port, input logic [4:0] dev,
                    input logic [15:0] addr, input logic [15:0] exp);
    frame(OP_ADDR, port, dev, addr);
    frame(OP_READ, port, dev, 16'h0000);
    check(rd_data, exp);
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      complete_run;
    end
  end

  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    straps = 4'h5;
    // one identity strap serves both groups
    id_strap = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_ADDR;
    cmd_port = 5'h00;
    cmd_dev = 5'h00;
    cmd_data = 16'h0000;
    fail_count = 0;
    checks = 0;
    cycles = 0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    check({1'b0, amp_ref, preemph, eq_en, eq_bw, lb_xgmii, lb_xaui,
           test_en}, 16'h0000);
    check({10'h0, pat_a, pat_b}, 16'h0000);
    wr(PA, DEVAD_DTE, REG_CFG1, 16'h784c);
    check({12'h0, preemph}, 16'h000f);
    check({amp_ref, eq_en, 14'h0}, 16'hc000);
    wr(PB, DEVAD_DTE, REG_CFG2, 16'h4000);
    check({13'h0, eq_bw}, 16'h0005);
    rd(PB, DEVAD_DTE, REG_CFG1, 16'h784c);
    frame(OP_ADDR, PA, DEVAD_DTE, REG_CFG1);
    frame(OP_RD_INC, PA, DEVAD_DTE, 16'h0000);
    check(rd_data, 16'h784c);
    frame(OP_READ, PA, DEVAD_DTE, 16'h0000);
    check(rd_data, 16'h4000);
    // Foreign identity: address and write both dropped
    wr(PA, 5'h01, 16'h9000, 16'h0000);
    frame(OP_READ, PA, DEVAD_DTE, 16'h0000);
    check(rd_data, 16'h4000);
    wr(PA, DEVAD_DTE, 16'h9000, 16'hffff);
    rd(PA, DEVAD_DTE, 16'h9000, 16'h0000);
    rd(PA, 5'h1e, REG_CFG1, 16'h0000);
    // Other port: no answer, line stays pulled up
    wr(5'h0c, DEVAD_DTE, REG_CFG1, 16'h0000);
    check({12'h0, preemph}, 16'h000f);
    rd(5'h1b, DEVAD_DTE, REG_CFG1, 16'hffff);
    // external loopback path belongs to the board
    wr(PA, DEVAD_DTE, REG_LOOPBACK, 16'h0001);
    wr(PB, DEVAD_DTE, REG_LOOPBACK, 16'h0002);
    check({12'h0, lb_xaui, lb_xgmii}, 16'h0009);
    frame(OP_ADDR, PA, DEVAD_DTE, REG_TEST);
    frame(OP_ADDR, PB, DEVAD_DTE, REG_TEST);
    for (int p = 0; p < 7; p++) begin
      frame(OP_WRITE, PA, DEVAD_DTE, 16'(p) | 16'h0008);
      frame(OP_WRITE, PB, DEVAD_DTE, 16'(6 - p));
      check({8'h0, test_en, pat_a, pat_b},
            {8'h0, 2'h1, 3'(p), 3'(6 - p)});
    end
    rd(PB, DEVAD_DTE, REG_STRAP, 16'h0017);
    wr(PB, DEVAD_DTE, REG_STRAP, 16'hffff);
    rd(PB, DEVAD_DTE, REG_STRAP, 16'h0017);
    @(posedge core_clk);
    id_strap <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(PA, DEVAD_PHY, REG_CFG1, 16'h784c);
    rd(PA, DEVAD_DTE, REG_CFG1, 16'h0000);
    complete_run;
  end
endmodule
